// ### rtl/lmce_pkg.sv
// Shared constants and types for the lock and digest command executor
package lmce_pkg;

  // ==========================================================
  // Opcodes and status bytes
  localparam logic [7:0] LMCE_OP_MAC = 8'h08;
  localparam logic [7:0] LMCE_OP_HMAC = 8'h11;
  localparam logic [7:0] LMCE_OP_LOCK = 8'h17;
  localparam logic [7:0] LMCE_ST_OK = 8'h00;
  localparam logic [7:0] LMCE_ST_MISCOMPARE = 8'h01;
  localparam logic [7:0] LMCE_ST_PARSE = 8'h03;
  localparam logic [7:0] LMCE_ST_EXEC = 8'h0f;

  // ==========================================================
  // Mode and zone parameter fields
  localparam int LMCE_MODE_CHAL_TEMP = 0;
  localparam int LMCE_MODE_KEY_TEMP = 1;
  localparam int LMCE_MODE_SRC = 2;
  localparam int LMCE_MODE_OTP88 = 4;
  localparam int LMCE_MODE_OTP64 = 5;
  localparam int LMCE_MODE_SN48 = 6;
  localparam logic [7:0] LMCE_MAC_RSVD = 8'h88;
  localparam logic [7:0] LMCE_HMAC_RSVD = 8'h8b;
  localparam int LMCE_ZONE_SEL = 0;
  localparam int LMCE_ZONE_NOCRC = 7;
  localparam logic [7:0] LMCE_ZONE_RSVD = 8'h7e;

  // ==========================================================
  // Lock bytes and zone sizes
  localparam logic [7:0] LMCE_LOCKED = 8'hff;
  localparam logic [7:0] LMCE_UNLOCKED = 8'h55;
  localparam logic [9:0] LMCE_CFG_BYTES = 10'd88;
  localparam logic [9:0] LMCE_DATA_BYTES = 10'd512;
  localparam logic [9:0] LMCE_OTP_BYTES = 10'd64;
  localparam logic [1:0] LMCE_ZN_CFG = 2'h0;
  localparam logic [1:0] LMCE_ZN_OTP = 2'h1;
  localparam logic [1:0] LMCE_ZN_DATA = 2'h2;

  // ==========================================================
  // CRC-16 shared with the transport blocks
  localparam logic [15:0] LMCE_CRC_POLY = 16'h8005;
  localparam logic [15:0] LMCE_CRC_INIT = 16'h0000;

  // ==========================================================
  // Digest message layout, byte offsets
  localparam logic [6:0] LMCE_MSG_B = 7'd32;
  localparam logic [6:0] LMCE_MSG_OP = 7'd64;
  localparam logic [6:0] LMCE_MSG_MODE = 7'd65;
  localparam logic [6:0] LMCE_MSG_KID = 7'd66;
  localparam logic [6:0] LMCE_MSG_OTPL = 7'd68;
  localparam logic [6:0] LMCE_MSG_OTPH = 7'd76;
  localparam logic [6:0] LMCE_MSG_SN8 = 7'd79;
  localparam logic [6:0] LMCE_MSG_SN47 = 7'd80;
  localparam logic [6:0] LMCE_MSG_SN01 = 7'd84;
  localparam logic [6:0] LMCE_MSG_SN23 = 7'd86;
  localparam logic [6:0] LMCE_MSG_LAST = 7'd87;

  // ==========================================================
  // Sequencer states
  typedef enum logic [4:0] {
    LMCE_IDLE = 5'h01,
    LMCE_CRC = 5'h02,
    LMCE_LOCK = 5'h04,
    LMCE_MSG = 5'h08,
    LMCE_WAIT = 5'h10
  } lmce_state_t;

endpackage : lmce_pkg

// ### rtl/lmce_crc_if.sv
// Carrier between the sequencer and the CRC-16 unit
`timescale 1ns/10ps
interface lmce_crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport master (output clr, output en, output data, input crc);
  modport slave (input clr, input en, input data, output crc);
endinterface : lmce_crc_if

// ### rtl/lmce_crc16.sv
// Bytewise CRC-16 accumulator, least significant bit of each byte first
`timescale 1ns/10ps
module lmce_crc16
  import lmce_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sequencer side
  lmce_crc_if.slave crc_if
);

  typedef struct packed {
    logic [15:0] crc;
  } lmce_crc_st_t;

  lmce_crc_st_t q;
  lmce_crc_st_t d;

  // ==========================================================
  // One byte folded in per enabled cycle
  always_comb
  begin
    d = q;
    if (crc_if.clr)
    begin
      d.crc = LMCE_CRC_INIT;
    end
    else if (crc_if.en)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (crc_if.data[b] ^ d.crc[15])
          d.crc = {d.crc[14:0], 1'b0} ^ LMCE_CRC_POLY;
        else
          d.crc = {d.crc[14:0], 1'b0};
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= '{crc: LMCE_CRC_INIT};
    else
      q <= d;
  end

  assign crc_if.crc = q.crc;

endmodule : lmce_crc16

// ### rtl/lmce_msg_byte.sv
// Picks one byte of the 88-byte digest message by its index
`timescale 1ns/10ps
module lmce_msg_byte
  import lmce_pkg::*;
(
  // Selection
  input wire logic [6:0] idx,
  input wire logic is_mac,
  input wire logic [7:0] opcode,
  input wire logic [7:0] mode,
  input wire logic [15:0] key_slot_selector,
  // Sources
  input wire logic [255:0] key_data,
  input wire logic [255:0] temp_digest_register,
  input wire logic [255:0] challenge,
  input wire logic [87:0] otp_bytes,
  input wire logic [71:0] serial_number_bytes,
  // Result
  output logic [7:0] msg_byte
);

  logic [4:0] k;
  logic otp_lo_on;

  assign k = idx[4:0];
  assign otp_lo_on = mode[LMCE_MODE_OTP88] | mode[LMCE_MODE_OTP64];

  // ==========================================================
  // Deselected fields read as zero so the length never changes
  always_comb
  begin
    msg_byte = 8'h00;
    if (idx < LMCE_MSG_B)
    begin
      if (is_mac)
        msg_byte = mode[LMCE_MODE_KEY_TEMP] ? temp_digest_register[k*8 +: 8] : key_data[k*8 +: 8];
    end
    else if (idx < LMCE_MSG_OP)
    begin
      if (!is_mac || mode[LMCE_MODE_CHAL_TEMP])
        msg_byte = temp_digest_register[k*8 +: 8];
      else
        msg_byte = challenge[k*8 +: 8];
    end
    else if (idx == LMCE_MSG_OP)
      msg_byte = opcode;
    else if (idx == LMCE_MSG_MODE)
      msg_byte = mode;
    else if (idx < LMCE_MSG_OTPL)
      msg_byte = idx[0] ? key_slot_selector[15:8] : key_slot_selector[7:0];
    else if (idx < LMCE_MSG_OTPH)
    begin
      if (otp_lo_on)
        msg_byte = otp_bytes[(7'(idx - LMCE_MSG_OTPL))*8 +: 8];
    end
    else if (idx < LMCE_MSG_SN8)
    begin
      if (mode[LMCE_MODE_OTP88])
        msg_byte = otp_bytes[(7'(idx - LMCE_MSG_OTPL))*8 +: 8];
    end
    else if (idx == LMCE_MSG_SN8)
      msg_byte = serial_number_bytes[71:64];
    else if (idx < LMCE_MSG_SN01)
    begin
      if (mode[LMCE_MODE_SN48])
        msg_byte = serial_number_bytes[(7'(idx - LMCE_MSG_SN47) + 7'd4)*8 +: 8];
    end
    else if (idx < LMCE_MSG_SN23)
      msg_byte = serial_number_bytes[(7'(idx - LMCE_MSG_SN01))*8 +: 8];
    else if (idx <= LMCE_MSG_LAST)
    begin
      if (mode[LMCE_MODE_SN48])
        msg_byte = serial_number_bytes[(7'(idx - LMCE_MSG_SN23) + 7'd2)*8 +: 8];
    end
  end

endmodule : lmce_msg_byte

// ### rtl/lmce_cmd_exec.sv
// Lock, keyed-hash and digest command execution for the authentication core
`timescale 1ns/10ps
module lmce_cmd_exec
  import lmce_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_param1,
  input wire logic [15:0] cmd_param2,
  input wire logic cmd_chal_present,
  input wire logic [255:0] cmd_challenge,
  // Stored device values
  input wire logic [255:0] temp_digest_register,
  input wire logic digest_source_flag,
  input wire logic [87:0] otp_bytes,
  input wire logic [71:0] serial_number_bytes,
  // Key slot read
  output logic [3:0] key_slot_selector,
  input wire logic [255:0] key_data,
  // Zone memory read, data one cycle after address
  output logic mem_rd_en,
  output logic [1:0] mem_rd_zone,
  output logic [9:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // Message stream to the hash engine
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [7:0] msg_byte,
  output logic msg_last,
  input wire logic sha_done,
  input wire logic [255:0] sha_digest,
  // Lock bytes
  output logic [7:0] config_zone_lock_byte,
  output logic [7:0] data_zone_lock_byte,
  // Response
  output logic resp_valid,
  output logic resp_is_digest,
  output logic [7:0] resp_status,
  output logic [255:0] resp_digest
);

  typedef struct packed {
    lmce_state_t state;
    logic [7:0] op;
    logic [7:0] mode;
    logic [15:0] p2;
    logic cmb;
    logic ovr;
    logic [9:0] idx;
    logic rdv;
    logic [7:0] cfg_lock;
    logic [7:0] dat_lock;
    logic resp_valid;
    logic resp_is_digest;
    logic [7:0] resp_status;
    logic [255:0] resp_digest;
    logic [3:0] key_sel;
  } lmce_top_st_t;

  lmce_top_st_t q;
  lmce_top_st_t d;

  lmce_crc_if crc_if ();

  logic [9:0] zone_len;
  logic issue;
  logic zone_locked;
  logic crc_clr;
  logic crc_pass;
  logic [7:0] err_code;

  // ==========================================================
  // Helper terms shared by the sequencer and the ports
  assign zone_len = q.cmb ? 10'(LMCE_DATA_BYTES + LMCE_OTP_BYTES) : LMCE_CFG_BYTES;
  assign issue = (q.state == LMCE_CRC) && (q.idx < zone_len);
  assign zone_locked = cmd_param1[LMCE_ZONE_SEL] ? (q.dat_lock != LMCE_UNLOCKED)
                                                 : (q.cfg_lock != LMCE_UNLOCKED);
  assign crc_pass = q.ovr || (crc_if.crc == q.p2);

  // Up-front parameter checks, so a refused command leaves the lock bytes alone and the sequencer in LMCE_IDLE
  always_comb
  begin
    err_code = LMCE_ST_OK;
    if (cmd_opcode == LMCE_OP_LOCK)
    begin
      if ((cmd_param1 & LMCE_ZONE_RSVD) != 8'h00)
        err_code = LMCE_ST_PARSE;
      else if (zone_locked)
        err_code = LMCE_ST_EXEC;
    end
    else if (cmd_opcode == LMCE_OP_MAC)
    begin
      if ((cmd_param1 & LMCE_MAC_RSVD) != 8'h00)
        err_code = LMCE_ST_PARSE;
      else if (!cmd_param1[LMCE_MODE_CHAL_TEMP] && !cmd_chal_present)
        err_code = LMCE_ST_PARSE;
      else if ((cmd_param1[LMCE_MODE_CHAL_TEMP] || cmd_param1[LMCE_MODE_KEY_TEMP])
               && (cmd_param1[LMCE_MODE_SRC] != digest_source_flag))
        err_code = LMCE_ST_EXEC;
    end
    else if (cmd_opcode == LMCE_OP_HMAC)
    begin
      if ((cmd_param1 & LMCE_HMAC_RSVD) != 8'h00)
        err_code = LMCE_ST_PARSE;
      else if (cmd_param1[LMCE_MODE_SRC] != digest_source_flag)
        err_code = LMCE_ST_EXEC;
    end
    else
      err_code = LMCE_ST_PARSE;
  end

  // ==========================================================
  // Sequencer
  always_comb
  begin
    d = q;
    d.resp_valid = 1'b0;
    crc_clr = 1'b0;
    unique case (q.state)
      LMCE_IDLE:
      begin
        if (cmd_valid)
        begin
          d.op = cmd_opcode;
          d.mode = cmd_param1;
          d.p2 = cmd_param2;
          d.cmb = cmd_param1[LMCE_ZONE_SEL];
          d.ovr = cmd_param1[LMCE_ZONE_NOCRC];
          d.idx = 10'd0;
          d.rdv = 1'b0;
          if (err_code != LMCE_ST_OK)
          begin
            d.resp_valid = 1'b1;
            d.resp_is_digest = 1'b0;
            d.resp_status = err_code;
          end
          else if (cmd_opcode == LMCE_OP_LOCK)
          begin
            crc_clr = 1'b1;
            if (cmd_param1[LMCE_ZONE_NOCRC])
              d.state = LMCE_LOCK;
            else
              d.state = LMCE_CRC;
          end
          else
          begin
            d.key_sel = cmd_param2[3:0];
            d.state = LMCE_MSG;
          end
        end
      end
      LMCE_CRC:
      begin
        // Address issue runs one ahead of the CRC fold
        d.rdv = issue;
        if (issue)
          d.idx = q.idx + 10'd1;
        else if (!q.rdv)
          d.state = LMCE_LOCK;
      end
      LMCE_LOCK:
      begin
        d.resp_valid = 1'b1;
        d.resp_is_digest = 1'b0;
        d.state = LMCE_IDLE;
        if (crc_pass)
        begin
          d.resp_status = LMCE_ST_OK;
          if (q.cmb)
            d.dat_lock = LMCE_LOCKED;
          else
            d.cfg_lock = LMCE_LOCKED;
        end
        else
          d.resp_status = LMCE_ST_MISCOMPARE;
      end
      LMCE_MSG:
      begin
        if (msg_ready)
        begin
          if (q.idx[6:0] == LMCE_MSG_LAST)
          begin
            d.idx = 10'd0;
            d.state = LMCE_WAIT;
          end
          else
            d.idx = q.idx + 10'd1;
        end
      end
      LMCE_WAIT:
      begin
        if (sha_done)
        begin
          d.resp_valid = 1'b1;
          d.resp_is_digest = 1'b1;
          d.resp_status = LMCE_ST_OK;
          d.resp_digest = sha_digest;
          d.state = LMCE_IDLE;
        end
      end
    endcase
  end

  // State register; lock bytes start unlocked
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.state <= LMCE_IDLE;
      q.cfg_lock <= LMCE_UNLOCKED;
      q.dat_lock <= LMCE_UNLOCKED;
    end
    else
      q <= d;
  end

  // ==========================================================
  // Zone CRC, fed from the memory one cycle after each address
  assign crc_if.clr = crc_clr;
  assign crc_if.en = q.rdv;
  assign crc_if.data = mem_rd_data;

  lmce_crc16 u_crc (
    .core_clk(core_clk),
    .rst(rst),
    .crc_if(crc_if)
  );

  // Config zone alone, or data zone first and then the one-time zone in the same pass
  assign mem_rd_en = issue;
  assign mem_rd_zone = !q.cmb ? LMCE_ZN_CFG : ((q.idx < LMCE_DATA_BYTES) ? LMCE_ZN_DATA : LMCE_ZN_OTP);
  assign mem_rd_addr = (q.cmb && (q.idx >= LMCE_DATA_BYTES)) ? 10'(q.idx - LMCE_DATA_BYTES) : q.idx;

  // ==========================================================
  // Message stream
  lmce_msg_byte u_msg (
    .idx(q.idx[6:0]),
    .is_mac(q.op == LMCE_OP_MAC),
    .opcode(q.op),
    .mode(q.mode),
    .key_slot_selector(q.p2),
    .key_data(key_data),
    .temp_digest_register(temp_digest_register),
    .challenge(cmd_challenge),
    .otp_bytes(otp_bytes),
    .serial_number_bytes(serial_number_bytes),
    .msg_byte(msg_byte)
  );

  assign msg_valid = (q.state == LMCE_MSG);
  assign msg_last = msg_valid && (q.idx[6:0] == LMCE_MSG_LAST);

  // Output drives
  assign cmd_ready = (q.state == LMCE_IDLE);
  assign key_slot_selector = q.key_sel;
  assign config_zone_lock_byte = q.cfg_lock;
  assign data_zone_lock_byte = q.dat_lock;
  assign resp_valid = q.resp_valid;
  assign resp_is_digest = q.resp_is_digest;
  assign resp_status = q.resp_status;
  assign resp_digest = q.resp_digest;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_lock_accept;
    cmd_valid && cmd_ready && (cmd_opcode == LMCE_OP_LOCK);
  endsequence

  sequence s_last_taken;
    msg_valid && msg_ready && msg_last;
  endsequence

  a_lock_sets_ff: assert property ((q.state == LMCE_LOCK) && crc_pass && !q.cmb
    |=> config_zone_lock_byte == 8'hff && resp_valid && resp_status == 8'h00)
    else $error("config lock byte not set on passing lock");
  a_relock_refused: assert property (s_lock_accept ##0 ((cmd_param1 & 8'h7e) == 8'h00) && zone_locked
    |=> resp_valid && resp_status == LMCE_ST_EXEC && cmd_ready)
    else $error("lock of locked zone not refused");
  a_crc_mismatch: assert property ((q.state == LMCE_LOCK) && !crc_pass
    |=> resp_valid && resp_status == LMCE_ST_MISCOMPARE && $stable(config_zone_lock_byte)
        && $stable(data_zone_lock_byte))
    else $error("mismatching summary still locked");
  a_zone_reserved: assert property (s_lock_accept ##0 (cmd_param1[6:1] != 6'h00)
    |=> resp_valid && resp_status == LMCE_ST_PARSE && $stable(config_zone_lock_byte))
    else $error("reserved zone bits accepted");
  a_cfg_crc_len: assert property ($rose(q.state == LMCE_CRC) && !q.cmb
    |-> ##88 !mem_rd_en ##1 q.state == LMCE_CRC ##1 q.state == LMCE_LOCK)
    else $error("config summary length not 88 bytes");
  a_override_skip: assert property (s_lock_accept ##0 cmd_param1 == 8'h80 && !zone_locked
    |=> q.state == LMCE_LOCK ##1 config_zone_lock_byte == 8'hff)
    else $error("override did not lock at once");
  a_opcode_place: assert property (msg_valid && q.idx == 10'd64 && q.op == LMCE_OP_MAC
    |-> msg_byte == 8'h08)
    else $error("digest opcode misplaced");
  a_sn8_kept: assert property (msg_valid && q.idx == 10'd79 |-> msg_byte == serial_number_bytes[71:64])
    else $error("serial byte 8 missing");
  a_sn_masked: assert property (msg_valid && !q.mode[6] && q.idx >= 10'd80 && q.idx <= 10'd83
    |-> msg_byte == 8'h00)
    else $error("serial bytes not zeroed");
  a_otp_masked: assert property (msg_valid && q.mode[5:4] == 2'b00 && q.idx >= 10'd68 && q.idx <= 10'd78
    |-> msg_byte == 8'h00)
    else $error("one-time bytes not zeroed");
  a_key_low: assert property (msg_valid |-> key_slot_selector == q.p2[3:0])
    else $error("slot select not from low id bits");
  a_src_check: assert property (cmd_valid && cmd_ready && cmd_opcode == LMCE_OP_HMAC
    && (cmd_param1 & LMCE_HMAC_RSVD) == 8'h00 && cmd_param1[LMCE_MODE_SRC] != digest_source_flag
    |=> resp_valid && resp_status == LMCE_ST_EXEC)
    else $error("source flag mismatch not refused");
  a_msg_done: assert property (s_last_taken |=> q.state == LMCE_WAIT)
    else $error("message did not end at byte 87");
  a_digest_out: assert property ((q.state == LMCE_WAIT) && sha_done
    |=> resp_valid && resp_is_digest && resp_digest == $past(sha_digest))
    else $error("digest not returned");

endmodule : lmce_cmd_exec

// ### tb/lmce_partner.sv
// Far side model: zone memory with one-cycle read and a stub hash engine
`timescale 1ns/10ps
module lmce_partner
  import lmce_pkg::*;
#(
  parameter logic [255:0] DIG = {8{32'h3c5a9e17}}
)
(
  // Clock, reset and pacing
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stall,
  // Zone memory
  input wire logic mem_rd_en,
  input wire logic [1:0] mem_rd_zone,
  input wire logic [9:0] mem_rd_addr,
  output logic [7:0] mem_rd_data,
  // Hash engine
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [7:0] msg_byte,
  input wire logic msg_last,
  output logic sha_done,
  output logic [255:0] sha_digest
);
  logic [7:0] msg [0:87];
  int idx, last_pos, wait_cnt;
  logic tick;
  // Slow pacing takes a byte every other cycle; digest is garbage outside the pulse
  assign msg_ready = !stall || tick;
  assign sha_digest = sha_done ? DIG : ~DIG;
  // Idle read line flips so a stale byte never passes for data
  always @(posedge core_clk)
    mem_rd_data <= mem_rd_en ? {mem_rd_zone, 6'h00} ^ mem_rd_addr[7:0] ^ {6'h00, mem_rd_addr[9:8]} : ~mem_rd_data;
  // Collect the message and answer a few cycles after its last byte
  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      tick <= 1'b0;
      idx <= 0;
      wait_cnt <= 0;
      sha_done <= 1'b0;
    end
    else
    begin
      tick <= !tick;
      sha_done <= (wait_cnt == 1);
      if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
      if (msg_valid && msg_ready)
      begin
        msg[idx] <= msg_byte;
        idx <= msg_last ? 0 : idx + 1;
        if (msg_last) last_pos <= idx;
        if (msg_last) wait_cnt <= 5;
      end
    end
endmodule : lmce_partner

// ### tb/tb_lock_and_mac_command_exec.sv
// Self-checking bench for the lock and digest command executor
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e); end end
module tb_lock_and_mac_command_exec
  import lmce_pkg::*;
;
  localparam logic [255:0] DIG = {8{32'h3c5a9e17}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_ready, cmd_chal_present, digest_source_flag, stall;
  logic mem_rd_en, msg_valid, msg_ready, msg_last, sha_done, resp_valid, resp_is_digest;
  logic [7:0] cmd_opcode, cmd_param1, mem_rd_data, msg_byte, resp_status, cfg_lock, data_lock;
  logic [15:0] cmd_param2;
  logic [255:0] cmd_challenge, tdr, key_data, sha_digest, resp_digest;
  logic [87:0] otp;
  logic [71:0] sn;
  logic [3:0] slot;
  logic [1:0] mem_rd_zone;
  logic [9:0] mem_rd_addr;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  lmce_cmd_exec lmce_cmd_exec_inst (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_param1,
    .cmd_param2, .cmd_chal_present, .cmd_challenge, .temp_digest_register(tdr), .digest_source_flag,
    .otp_bytes(otp), .serial_number_bytes(sn), .key_slot_selector(slot), .key_data, .mem_rd_en,
    .mem_rd_zone, .mem_rd_addr, .mem_rd_data, .msg_valid, .msg_ready, .msg_byte, .msg_last, .sha_done,
    .sha_digest, .config_zone_lock_byte(cfg_lock), .data_zone_lock_byte(data_lock), .resp_valid,
    .resp_is_digest, .resp_status, .resp_digest);
  lmce_partner #(.DIG(DIG)) lmce_partner_inst (.core_clk, .rst, .stall, .mem_rd_en, .mem_rd_zone,
    .mem_rd_addr, .mem_rd_data, .msg_valid, .msg_ready, .msg_byte, .msg_last, .sha_done, .sha_digest);

  // ==========================================================
  // Clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Reference values
  function automatic logic [7:0] mv(input logic [1:0] z, input logic [9:0] a);
    return {z, 6'h00} ^ a[7:0] ^ {6'h00, a[9:8]};
  endfunction : mv

  // Bitwise CRC, lsb of each byte first; data zone precedes one-time zone
  function automatic logic [15:0] zcrc(input logic both);
    logic [15:0] c;
    logic [7:0] d;
    c = 16'h0000;
    for (int i = 0; i < (both ? 576 : 88); i++)
    begin
      d = !both ? mv(2'h0, 10'(i)) : (i < 512 ? mv(2'h2, 10'(i)) : mv(2'h1, 10'(i - 512)));
      for (int b = 0; b < 8; b++)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction : zcrc

  // Expected message byte i for a given opcode, mode and key id
  function automatic logic [7:0] eb(input int i, input logic [7:0] op, md, input logic [15:0] kid);
    logic mac;
    mac = (op == LMCE_OP_MAC);
    if (i < 32) return !mac ? 8'h00 : md[1] ? tdr[8*i +: 8] : key_data[8*i +: 8];
    if (i < 64) return (mac && !md[0]) ? cmd_challenge[8*(i-32) +: 8] : tdr[8*(i-32) +: 8];
    if (i < 66) return i == 64 ? op : md;
    if (i < 68) return kid[8*(i-66) +: 8];
    if (i < 76) return (md[4] || md[5]) ? otp[8*(i-68) +: 8] : 8'h00;
    if (i < 79) return md[4] ? otp[8*(i-68) +: 8] : 8'h00;
    if (i == 79) return sn[71:64];
    if (i < 84) return md[6] ? sn[8*(i-76) +: 8] : 8'h00;
    if (i < 86) return sn[8*(i-84) +: 8];
    return md[6] ? sn[8*(i-84) +: 8] : 8'h00;
  endfunction : eb

  // ==========================================================
  // Drivers; lat counts cycles from the take edge to the response
  task automatic cmd(input logic [7:0] op, p1, input logic [15:0] p2, input logic ch, output int lat);
    @(negedge core_clk);
    cmd_opcode = op;
    cmd_param1 = p1;
    cmd_param2 = p2;
    cmd_chal_present = ch;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    lat = 0;
    do
    begin
      @(negedge core_clk);
      cmd_valid = 1'b0;
      lat++;
    end
    while (resp_valid !== 1'b1 && lat < 2000);
  endtask : cmd

  task automatic lock(input logic [7:0] p1, input logic [15:0] p2, input logic [7:0] st, input int el);
    int lat;
    cmd(LMCE_OP_LOCK, p1, p2, 1'b0, lat);
    `CHK(resp_status, st)
    `CHK(resp_is_digest, 1'b0)
    if (el > 0) `CHK(lat, el)
  endtask : lock

  task automatic mac(input logic [7:0] op, md, input logic [15:0] kid, input logic ch, input logic [7:0] st);
    int lat;
    cmd(op, md, kid, ch, lat);
    `CHK(lat < 2000, 1'b1)
    if (st != LMCE_ST_OK) `CHK(resp_status, st)
    if (st != LMCE_ST_OK) `CHK(resp_is_digest, 1'b0)
    if (st == LMCE_ST_OK)
    begin
      `CHK(resp_is_digest, 1'b1)
      `CHK(resp_digest, DIG)
      `CHK(lmce_partner_inst.last_pos, 87)
      for (int i = 0; i < 88; i++) `CHK(lmce_partner_inst.msg[i], eb(i, op, md, kid))
      `CHK(slot, kid[3:0])
    end
  endtask : mac

  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    `CHK(cfg_lock, LMCE_UNLOCKED)
    `CHK(data_lock, LMCE_UNLOCKED)
  endtask : do_reset

  task automatic end_sim();
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Scenarios
  task automatic t_lock();
    lock(8'h00, zcrc(1'b0) ^ 16'h0001, LMCE_ST_MISCOMPARE, 0);
    `CHK(cfg_lock, LMCE_UNLOCKED)
    lock(8'h00, zcrc(1'b0), LMCE_ST_OK, 92);
    `CHK(cfg_lock, LMCE_LOCKED)
    `CHK(data_lock, LMCE_UNLOCKED)
    lock(8'h80, 16'h0000, LMCE_ST_EXEC, 0);
    lock(8'h03, zcrc(1'b1), LMCE_ST_PARSE, 0);
    lock(8'h41, zcrc(1'b1), LMCE_ST_PARSE, 0);
    `CHK(data_lock, LMCE_UNLOCKED)
    lock(8'h01, zcrc(1'b1), LMCE_ST_OK, 580);
    `CHK(data_lock, LMCE_LOCKED)
    do_reset();
    lock(8'h81, 16'h0000, LMCE_ST_OK, 2);
    lock(8'h80, 16'h0000, LMCE_ST_OK, 2);
    `CHK(cfg_lock & data_lock, LMCE_LOCKED)
  endtask : t_lock

  task automatic t_digest();
    digest_source_flag = 1'b1;
    mac(LMCE_OP_MAC, 8'h00, 16'h5a3c, 1'b1, LMCE_ST_OK);
    stall = 1'b1;
    mac(LMCE_OP_MAC, 8'h57, 16'h0007, 1'b0, LMCE_ST_OK);
    stall = 1'b0;
    mac(LMCE_OP_MAC, 8'h03, 16'h0001, 1'b0, LMCE_ST_EXEC);
    mac(LMCE_OP_MAC, 8'h80, 16'h0001, 1'b1, LMCE_ST_PARSE);
    mac(LMCE_OP_MAC, 8'h00, 16'h0001, 1'b0, LMCE_ST_PARSE);
    mac(LMCE_OP_HMAC, 8'h64, 16'hc3a2, 1'b0, LMCE_ST_OK);
    mac(LMCE_OP_HMAC, 8'h34, 16'h0002, 1'b0, LMCE_ST_OK);
    mac(LMCE_OP_HMAC, 8'h00, 16'h0002, 1'b0, LMCE_ST_EXEC);
    digest_source_flag = 1'b0;
    mac(LMCE_OP_HMAC, 8'h10, 16'h0009, 1'b0, LMCE_ST_OK);
    mac(8'h42, 8'h00, 16'h0000, 1'b0, LMCE_ST_PARSE);
  endtask : t_digest

  // ==========================================================
  // Main sequence
  initial
  begin
    {cmd_valid, cmd_chal_present, digest_source_flag, stall} = 4'h0;
    {cmd_opcode, cmd_param1, cmd_param2} = 32'h0;
    for (int k = 0; k < 32; k++)
    begin
      tdr[8*k +: 8] = 8'h40 + 8'(k);
      cmd_challenge[8*k +: 8] = 8'h80 + 8'(k);
      key_data[8*k +: 8] = 8'hc0 + 8'(k);
      if (k < 11) otp[8*k +: 8] = 8'h10 + 8'(k);
      if (k < 9) sn[8*k +: 8] = 8'h20 + 8'(k);
    end
    do_reset();
    t_lock();
    t_digest();
    end_sim();
  end
endmodule : tb_lock_and_mac_command_exec
